// >>> src/pmc_top.sv
// Purpose: Power mode controller: RUN, SLOW, WAIT, SLOW-WAIT, ACTIVE-HALT, HALT.
// Assumes: APB register access; wait/halt instructions and wake events are synchronous.
// Notes: Clock gating, divider enables and interrupt level forcing are outputs.
//
// Operation
// - Reset enters RUN on master clock
// - Slow enable and divider field in register
// - Slow divides master clock by 2..16
// - Wait in slow gives slow-wait, reduced clock
// - Wait stops CPU, peripherals stay clocked
// - Wait entry forces interrupt level to 10
// - Wait exits only on interrupt or reset
// - Halt picks active-halt by oscillator enable
// - Active-halt exits on timebase, wakeable irq, reset
// - Active-halt interrupt exit skips stabilisation delay
// - Active-halt entry forces level 10, pending wakes
// - Active-halt keeps only oscillator and timebase
// - Active-halt with oscillator enable freezes watchdog
// - Stabilisation delay after halt wake, or if oscillator enable is cleared in the post-wake window
// - Push CC, set level, restore on pop
// - Halt stops oscillator and all clocks
// - Halt exit restarts oscillator, waits delay
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_top
  import pmc_pkg::*;
#(
  parameter int DLY_SHORT = `PMC_DLY_SHORT,
  parameter int DLY_LONG = `PMC_DLY_LONG
)
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU core
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  input wire logic cc_push,
  input wire logic cc_pop,
  input wire logic [1:0] irq_level,
  // Interrupt controller wake events
  input wire pmc_wake_t wake,
  // Power state and gating
  output pmc_mode_t mode,
  output pmc_gate_t gate,
  output logic cpu_clk_tick,
  output logic [1:0] cc_ilvl,
  output logic irq_service
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [4:0] ctrl;
  logic [4:0] next_ctrl;
  logic [1:0] ilvl;
  logic [1:0] next_ilvl;
  logic [1:0] ilvl_saved;
  logic [1:0] next_ilvl_saved;
  pmc_mode_t next_mode;
  pmc_gate_t next_gate;
  logic [12:0] dly;
  logic [12:0] next_dly;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic next_tick;
  logic next_service;
  logic post_wake;
  logic next_post_wake;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic access;
  logic wr;
  logic cmd_wait;
  logic cmd_halt;
  logic slow_en;
  logic oscillator_irq_enable;
  logic [1:0] div_sel;
  logic [12:0] dly_len;
  logic [3:0] div_max;

  assign access = psel && penable && !pready;
  assign wr = access && pwrite;
  assign slow_en = ctrl[`PMC_SLOW_EN_BIT];
  assign oscillator_irq_enable = ctrl[`PMC_OIE_BIT];
  assign div_sel = ctrl[`PMC_DIV_LSB +: 2];
  // Long or short stabilisation chosen by a software bit (option byte stand-in)
  assign dly_len = ctrl[`PMC_LONG_DLY_BIT] ? 13'(DLY_LONG - 1) : 13'(DLY_SHORT - 1);
  // Divide by 2, 4, 8 or 16
  // Shift amount widened first: a 2-bit sum would wrap to zero for divide by 16
  assign div_max = 4'((5'h01 << ({1'b0, div_sel} + 3'h1)) - 5'h01);
  assign cmd_wait = wait_for_irq_instr
    || (wr && paddr == `PMC_CPU_CMD_OFS && pwdata[`PMC_CMD_WAIT_BIT]);
  assign cmd_halt = halt_instr
    || (wr && paddr == `PMC_CPU_CMD_OFS && pwdata[`PMC_CMD_HALT_BIT]);

  // ------------------------------------------------------------------
  // APB register file
  // ------------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pready = access;
    next_pslverr = 1'b0;
    if (access)
    begin
      next_prdata = 32'h0000_0000;
      if (paddr == `PMC_CLK_CTRL_OFS)
      begin
        if (pwrite)
        begin
          next_ctrl = pwdata[4:0];
        end
        next_prdata = {27'h000_0000, ctrl};
      end
      else if (paddr == `PMC_CPU_CMD_OFS)
      begin
        next_prdata = 32'h0000_0000;
      end
      else if (paddr == `PMC_STATUS_OFS)
      begin
        next_prdata = {15'h0000, dly, 1'b0, mode};
      end
      else if (paddr == `PMC_CC_OFS)
      begin
        next_prdata = {30'h0000_0000, ilvl};
      end
      else
      begin
        next_pslverr = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    next_dly = dly;
    next_ilvl = ilvl;
    next_ilvl_saved = ilvl_saved;
    next_service = 1'b0;
    next_post_wake = post_wake;
    case (mode)
      PMC_RUN, PMC_SLOW:
      begin
        next_mode = slow_en ? PMC_SLOW : PMC_RUN;
        if (cmd_wait)
        begin
          next_mode = slow_en ? PMC_SLOW_WAIT : PMC_WAIT;
          next_ilvl = `PMC_CC_ILVL_OPEN;
        end
        else if (cmd_halt)
        begin
          next_mode = oscillator_irq_enable ? PMC_ACT_HALT : PMC_HALT;
          next_ilvl = `PMC_CC_ILVL_OPEN;
        end
      end
      PMC_WAIT, PMC_SLOW_WAIT:
      begin
        // Other registers untouched; only an interrupt leaves
        if (wake.any)
        begin
          next_mode = slow_en ? PMC_SLOW : PMC_RUN;
          next_service = 1'b1;
        end
      end
      PMC_ACT_HALT:
      begin
        // Pending wake in the entry cycle leaves at once
        if (wake.timebase || wake.halt_wakeable)
        begin
          next_mode = slow_en ? PMC_SLOW : PMC_RUN;
          next_service = 1'b1;
          next_post_wake = 1'b1;
          next_dly = dly_len;
        end
      end
      PMC_HALT:
      begin
        if (wake.halt_wakeable)
        begin
          next_mode = PMC_STARTUP;
          next_dly = dly_len;
        end
      end
      PMC_STARTUP:
      begin
        if (dly == 13'h0000)
        begin
          next_mode = slow_en ? PMC_SLOW : PMC_RUN;
          next_service = !post_wake;
          next_post_wake = 1'b0;
        end
        else
        begin
          next_dly = dly - 13'h0001;
        end
      end
      default:
      begin
        next_mode = PMC_RUN;
      end
    endcase
    // Clearing the oscillator enable inside the post-wake window drops to
    // startup for the rest of it; software is expected not to do this.
    // A fresh active-halt wake reloads the window instead of counting it down
    if (post_wake && mode != PMC_STARTUP && mode != PMC_ACT_HALT && next_mode != PMC_ACT_HALT)
    begin
      if (!oscillator_irq_enable)
      begin
        next_mode = PMC_STARTUP;
      end
      else if (dly == 13'h0000)
      begin
        next_post_wake = 1'b0;
      end
      else
      begin
        next_dly = dly - 13'h0001;
      end
    end
    // Interrupt entry saves the level, return restores it
    if (cc_push)
    begin
      next_ilvl_saved = ilvl;
      next_ilvl = irq_level;
    end
    else if (cc_pop)
    begin
      next_ilvl = ilvl_saved;
    end
  end

  // ------------------------------------------------------------------
  // Clock divider and gating
  // ------------------------------------------------------------------
  always_comb
  begin
    next_div_cnt = 4'h0;
    next_tick = 1'b1;
    if (slow_en)
    begin
      next_tick = (div_cnt == div_max);
      next_div_cnt = next_tick ? 4'h0 : div_cnt + 4'h1;
    end
    next_gate.cpu_clk_en = (next_mode == PMC_RUN) || (next_mode == PMC_SLOW);
    next_gate.periph_clk_en = (next_mode == PMC_RUN) || (next_mode == PMC_SLOW)
      || (next_mode == PMC_WAIT) || (next_mode == PMC_SLOW_WAIT);
    next_gate.osc_en = (next_mode != PMC_HALT);
    next_gate.timebase_clk_en = next_gate.osc_en && (next_mode != PMC_STARTUP);
    next_gate.wdg_freeze = (next_mode == PMC_ACT_HALT) && oscillator_irq_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `PMC_CLK_CTRL_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode <= PMC_RUN;
      dly <= 13'h0000;
      ilvl <= `PMC_CC_ILVL_RST;
      ilvl_saved <= `PMC_CC_ILVL_RST;
      post_wake <= 1'b0;
      div_cnt <= 4'h0;
      cpu_clk_tick <= 1'b1;
      irq_service <= 1'b0;
      gate <= 5'b11110;
      cc_ilvl <= `PMC_CC_ILVL_RST;
    end
    else if (clk_en)
    begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      mode <= next_mode;
      dly <= next_dly;
      ilvl <= next_ilvl;
      ilvl_saved <= next_ilvl_saved;
      post_wake <= next_post_wake;
      div_cnt <= next_div_cnt;
      cpu_clk_tick <= next_tick;
      irq_service <= next_service;
      gate <= next_gate;
      cc_ilvl <= next_ilvl;
    end
  end

endmodule // pmc_top
`default_nettype wire

// >>> shared/pmc_defs.svh
// Purpose: Constants for the power mode controller (offsets, fields, reset values, timing).
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes: Included by the design module.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define PMC_CLK_CTRL_OFS 12'h000
`define PMC_CPU_CMD_OFS 12'h004
`define PMC_STATUS_OFS 12'h008
`define PMC_CC_OFS 12'h00C

// ------------------------------------------------------------------
// Field positions of the clock control register
// ------------------------------------------------------------------
`define PMC_SLOW_EN_BIT 0
`define PMC_DIV_LSB 1
`define PMC_OIE_BIT 3
`define PMC_LONG_DLY_BIT 4

// Command register: bit 0 wait, bit 1 halt (self-clearing)
`define PMC_CMD_WAIT_BIT 0
`define PMC_CMD_HALT_BIT 1

// ------------------------------------------------------------------
// Reset values and encodings
// ------------------------------------------------------------------
`define PMC_CLK_CTRL_RST 5'h00
`define PMC_CC_ILVL_RST 2'h3
`define PMC_CC_ILVL_OPEN 2'h2

// ------------------------------------------------------------------
// Stabilisation delay, in master clock cycles
// ------------------------------------------------------------------
`define PMC_DLY_SHORT 256
`define PMC_DLY_LONG 4096

`endif

// >>> shared/pmc_pkg.sv
// Purpose: Types shared by the power mode controller.
// Assumes: pmc_defs.svh in the include path.
// Notes: Mode encoding is also the mode field of the status register.
package pmc_pkg;

  // ------------------------------------------------------------------
  // Power modes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_SLOW = 3'b001,
    PMC_WAIT = 3'b010,
    PMC_SLOW_WAIT = 3'b011,
    PMC_ACT_HALT = 3'b100,
    PMC_HALT = 3'b101,
    PMC_STARTUP = 3'b110
  } pmc_mode_t;

  // ------------------------------------------------------------------
  // Clock gating bundle
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic timebase_clk_en;
    logic wdg_freeze;
  } pmc_gate_t;

  // Wake request from the interrupt controller
  typedef struct packed {
    logic timebase;
    logic halt_wakeable;
    logic any;
  } pmc_wake_t;

endpackage

// >>> dv/pmc_props.sv
// Purpose: Checker of mode, gating and level behaviour
// Assumes: One clock, clk_en held high by the bench
// Notes: Bound to pmc_top; ctrl mirrors the clock control word
`timescale 1ns/100ps
`default_nettype none
module pmc_props
  import pmc_pkg::*;
#(
  parameter int DLY_SHORT = 4,
  parameter int DLY_LONG = 8
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // CPU and wake
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  input wire logic cc_push,
  input wire logic [1:0] irq_level,
  input wire pmc_wake_t wake,
  // Outputs
  input wire pmc_mode_t mode,
  input wire pmc_gate_t gate,
  input wire logic cpu_clk_tick,
  input wire logic [1:0] cc_ilvl,
  input wire logic irq_service
);
  localparam int MAXW = DLY_LONG + 2;
  logic [4:0] ctrl;
  logic [4:0] next_ctrl;
  always_comb
  begin
    next_ctrl = ctrl;
    if (psel && penable && pready && pwrite && paddr == 12'h000)
      next_ctrl = pwdata[4:0];
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl <= 5'h00;
    else
      ctrl <= next_ctrl;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence idle_s; mode inside {PMC_RUN, PMC_SLOW}; endsequence
  sequence halt_wake_s; mode == PMC_HALT && wake.halt_wakeable; endsequence
  sequence restart_s; mode == PMC_STARTUP && gate.osc_en; endsequence
  run_tick_a: assert property (mode == PMC_RUN |-> cpu_clk_tick)
    else $error("no tick in run");
  wait_lvl_a: assert property (idle_s ##0 wait_for_irq_instr |=> cc_ilvl == 2'h2 &&
    mode == ($past(mode) == PMC_SLOW ? PMC_SLOW_WAIT : PMC_WAIT)) else $error("bad wait entry");
  wait_gate_a: assert property (mode inside {PMC_WAIT, PMC_SLOW_WAIT} |->
    !gate.cpu_clk_en && gate.periph_clk_en) else $error("bad wait gating");
  wait_hold_a: assert property (mode inside {PMC_WAIT, PMC_SLOW_WAIT} && !wake.any
    |=> $stable(mode)) else $error("wait left without wake");
  halt_pick_a: assert property (idle_s ##0 (halt_instr && !wait_for_irq_instr) |=>
    mode == (ctrl[3] ? PMC_ACT_HALT : PMC_HALT) && cc_ilvl == 2'h2) else $error("bad halt entry");
  act_gate_a: assert property (mode == PMC_ACT_HALT |-> gate == 5'h07)
    else $error("bad active halt gating");
  act_wake_a: assert property (mode == PMC_ACT_HALT && (wake.timebase || wake.halt_wakeable)
    |=> mode == PMC_RUN && irq_service) else $error("slow active halt exit");
  halt_gate_a: assert property (mode == PMC_HALT |-> gate == 5'h00)
    else $error("clocks alive in halt");
  halt_exit_a: assert property (halt_wake_s |=> restart_s ##[1:MAXW]
    (mode == PMC_RUN && irq_service)) else $error("bad halt restart");
  push_lvl_a: assert property (cc_push |=> cc_ilvl == $past(irq_level))
    else $error("level not taken on push");
  apb_ready_a: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
endmodule // pmc_props
bind pmc_top pmc_props #(.DLY_SHORT(DLY_SHORT), .DLY_LONG(DLY_LONG)) pmc_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .wait_for_irq_instr(wait_for_irq_instr),
  .halt_instr(halt_instr), .cc_push(cc_push), .irq_level(irq_level), .wake(wake), .mode(mode),
  .gate(gate), .cpu_clk_tick(cpu_clk_tick), .cc_ilvl(cc_ilvl), .irq_service(irq_service));
`default_nettype wire

// >>> dv/pmc_irq_model.sv
// Purpose: Interrupt controller stand-in raising wake lines
// Assumes: Bench holds req until service
// Notes: Request latch clears on service, as a vector fetch does
`timescale 1ns/100ps
`default_nettype none
module pmc_irq_model
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request, latency, acknowledge
  input wire pmc_wake_t req,
  input wire logic [3:0] lat,
  input wire logic irq_service,
  // Wake lines
  output pmc_wake_t wake
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  pmc_wake_t next_wake;
  always_comb
  begin
    next_cnt = 4'h0;
    next_wake = wake;
    if (irq_service)
      next_wake = 3'h0;
    else if (req != 3'h0 && cnt >= lat)
      next_wake = req;
    else if (req != 3'h0)
      next_cnt = cnt + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {wake, cnt} <= 7'h00;
    else
      {wake, cnt} <= {next_wake, next_cnt};
endmodule // pmc_irq_model
`default_nettype wire

// >>> dv/tb_power_mode_controller.sv
// Purpose: Self-checking bench of the power mode controller
// Assumes: Delays shortened to 4 and 8
// Notes: Every APB answer is checked against a queued note
`timescale 1ns/100ps
`default_nettype none
module tb_power_mode_controller;
  import pmc_pkg::*;
  localparam logic [11:0] CTRL = 12'h000, STAT = 12'h008, CCR = 12'h00C;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic halt_instr = 1'b0, wait_for_irq_instr = 1'b0, cc_push = 1'b0, cc_pop = 1'b0;
  logic [1:0] irq_level = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_clk_tick, irq_service;
  logic [1:0] cc_ilvl;
  pmc_mode_t mode;
  pmc_gate_t gate;
  pmc_wake_t wake;
  pmc_wake_t req = 3'h0;
  logic [3:0] lat = 4'h0;
  logic [32:0] m;
  logic [32:0] expq[$];
  logic [32:0] mskq[$];
  int miscompares = 0, check_count = 0, cyc = 0, n, div, lv;
  always #10 pclk = ~pclk;
  pmc_top #(.DLY_SHORT(4), .DLY_LONG(8)) pmc_top_i (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_for_irq_instr(wait_for_irq_instr), .halt_instr(halt_instr), .cc_push(cc_push),
    .cc_pop(cc_pop), .irq_level(irq_level), .wake(wake), .mode(mode), .gate(gate),
    .cpu_clk_tick(cpu_clk_tick), .cc_ilvl(cc_ilvl), .irq_service(irq_service));
  pmc_irq_model pmc_irq_model_i (.pclk(pclk), .presetn(presetn), .req(req), .lat(lat),
    .irq_service(irq_service), .wake(wake));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] mk, input logic [32:0] e);
    expq.push_back(e);
    mskq.push_back(mk);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {1'b1, mk}, {1'b0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h1_0000_0000, 33'h0_0000_0000);
  endtask
  task automatic ins(input logic [1:0] v);
    @(posedge pclk);
    {halt_instr, wait_for_irq_instr} <= v;
    @(posedge pclk);
    {halt_instr, wait_for_irq_instr} <= 2'h0;
  endtask
  task automatic serv(input pmc_wake_t w);
    req <= w;
    lat <= 4'($urandom_range(7, 0));
    @(posedge pclk iff irq_service === 1'b1);
    req <= 3'h0;
  endtask
  always @(posedge pclk)
    if (pready === 1'b1 && mskq.size() > 0)
    begin
      m = mskq.pop_front();
      chk({pslverr, prdata} & m, expq.pop_front() & m);
    end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      final_report();
    end
  end
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    void'($urandom(54491));
    div = $urandom_range(3, 0);
    lv = $urandom_range(3, 0);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(STAT, 32'h0000_0007, PMC_RUN);
    rd(CCR, 32'h0000_0003, 32'h0000_0003);
    apb(1'b0, 12'h010, 32'h0000_0000, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
    wr(CTRL, 32'({div[1:0], 1'b1}));
    rd(CTRL, 32'h0000_001F, 32'({div[1:0], 1'b1}));
    rd(STAT, 32'h0000_0007, PMC_SLOW);
    n = 0;
    repeat (64) @(posedge pclk) n += cpu_clk_tick;
    chk(n, 64 >> (div + 1));
    ins(2'h1);
    rd(STAT, 32'h0000_0007, PMC_SLOW_WAIT);
    rd(CCR, 32'h0000_0003, 32'h0000_0002);
    serv(3'h1);
    rd(STAT, 32'h0000_0007, PMC_SLOW);
    rd(CTRL, 32'h0000_001F, 32'({div[1:0], 1'b1}));
    irq_level <= 2'(lv);
    cc_push <= 1'b1;
    @(posedge pclk);
    cc_push <= 1'b0;
    rd(CCR, 32'h0000_0003, lv);
    cc_pop <= 1'b1;
    @(posedge pclk);
    cc_pop <= 1'b0;
    rd(CCR, 32'h0000_0003, 32'h0000_0002);
    wr(CTRL, 32'h0000_0008);
    ins(2'h2);
    rd(STAT, 32'h0000_0007, PMC_ACT_HALT);
    rd(CCR, 32'h0000_0003, 32'h0000_0002);
    serv(3'h5);
    rd(STAT, 32'h0000_0007, PMC_RUN);
    // Enable stays set until the post-wake window is over
    repeat (12) @(posedge pclk);
    req <= 3'h3;
    ins(2'h2);
    serv(3'h3);
    rd(STAT, 32'h0000_0007, PMC_RUN);
    wr(CTRL, 32'h0000_0010);
    ins(2'h2);
    rd(STAT, 32'h0000_0007, PMC_HALT);
    n = 0;
    req <= 3'h3;
    lat <= 4'h0;
    do begin @(posedge pclk); n++; end while (irq_service !== 1'b1);
    req <= 3'h0;
    chk(n >= 10, 1'b1);
    rd(STAT, 32'h0000_0007, PMC_RUN);
    final_report();
  end
endmodule // tb_power_mode_controller
`default_nettype wire
